/* design/mcf_dev.sv */
// device end: lower config fields, capability readout, control protection
// assumes the host holds req until ack and keeps its ordering duties
`timescale 1ns/10ps
module mcf_dev (
  input wire logic core_clk_i,
  input wire logic rst_i,
  mcf_link_if.dev link,
  input wire logic generic_i,
  input wire logic protect_pin_i,
  input wire logic chunk_valid_i,
  input wire logic chunk_toggle_bit_i,
  output logic rx_cut_through_on_o,
  output logic frame_stamp_on_o,
  output logic stamp_size_select_o,
  output logic control_protection_on_o,
  output logic chunk_retry_on_o,
  output logic rewrite_ok_o,
  output logic [7:0] chunk_bytes_o,
  output logic sync_o,
  output logic chk_err_o
);
  import mcf_pkg::*;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [31:0] rchk;
    logic rx_ct;
    logic stamp_on;
    logic stamp_64;
    logic prot;
    logic strap_done;
    logic retry_on;
    logic [2:0] chunk_payload_selector;
    logic sync;
    logic last_toggle;
    logic rewrite_ok;
    logic [7:0] chunk_bytes;
  } mcf_dev_state_t;

  localparam mcf_dev_state_t RESET_STATE = '{
    ack: 1'b0,
    err: 1'b0,
    rdata: `MCF_ZERO32,
    rchk: `MCF_ZERO32,
    rx_ct: 1'b0,
    stamp_on: 1'b0,
    stamp_64: 1'b0,
    prot: 1'b0,
    strap_done: 1'b0,
    retry_on: 1'b0,
    chunk_payload_selector: `MCF_CPS_RESET,
    sync: 1'b0,
    last_toggle: 1'b0,
    rewrite_ok: 1'b0,
    chunk_bytes: 8'h00
  };

  mcf_dev_state_t st_r;
  mcf_dev_state_t st_nxt;

  function automatic mcf_word_t cfg0_image(input mcf_dev_state_t s);
    mcf_word_t w;
    w = `MCF_ZERO32;
    w[`MCF_SYNC_BIT] = s.sync;
    w[`MCF_RXCT_BIT] = s.rx_ct;
    w[`MCF_STAMP_BIT] = s.stamp_on;
    w[`MCF_SIZE_BIT] = s.stamp_64;
    w[`MCF_PROT_BIT] = s.prot;
    w[`MCF_RETRY_BIT] = s.retry_on;
    w[`MCF_CPS_HI:`MCF_CPS_LO] = s.chunk_payload_selector;
    return w;
  endfunction : cfg0_image

  // address decode, shared by the write path and the read path
  function automatic logic hits_cfg0(input logic [7:0] a);
    return a == `MCF_CFG0_ADDR;
  endfunction : hits_cfg0

  function automatic logic hits_cap(input logic [7:0] a);
    return a == `MCF_CAP_ADDR;
  endfunction : hits_cap

  function automatic logic cps_legal(input logic [2:0] sel);
    return sel >= `MCF_CPS_MIN && sel <= `MCF_CPS_MAX;
  endfunction : cps_legal

  // payload bytes for a selector; zero on the generic protocol
  function automatic logic [7:0] payload_bytes(input logic [2:0] sel, input logic generic);
    return generic ? 8'h00 : (`MCF_BYTES_ONE << sel);
  endfunction : payload_bytes

  // read image for one address; unknown addresses read as zero
  function automatic mcf_word_t read_word(input mcf_dev_state_t s, input logic [7:0] a);
    mcf_word_t w;
    w = `MCF_ZERO32;
    if (hits_cfg0(a)) begin
      w = cfg0_image(s);
    end else if (hits_cap(a)) begin
      w[`MCF_CPS_HI:`MCF_CPS_LO] = `MCF_CPS_MIN;
    end
    return w;
  endfunction : read_word

  // one accepted config write; the strap bit and reserved bits stay put
  function automatic mcf_dev_state_t write_cfg0(input mcf_dev_state_t s, input mcf_word_t d);
    mcf_dev_state_t n;
    n = s;
    n.rx_ct = d[`MCF_RXCT_BIT];
    n.stamp_on = d[`MCF_STAMP_BIT];
    n.stamp_64 = d[`MCF_SIZE_BIT];
    n.retry_on = d[`MCF_RETRY_BIT];
    // selectors outside 3..6 are dropped, keeping the last legal size
    if (cps_legal(d[`MCF_CPS_HI:`MCF_CPS_LO])) begin
      n.chunk_payload_selector = d[`MCF_CPS_HI:`MCF_CPS_LO];
    end
    // write-one-sets; only reset clears it
    if (d[`MCF_SYNC_BIT]) begin
      n.sync = 1'b1;
    end
    return n;
  endfunction : write_cfg0

  always_comb begin
    mcf_word_t rd;
    logic chk_ok;
    logic take;
    logic wr_cfg0;
    rd = read_word(st_r, link.addr);
    // only check-word when protection is on
    chk_ok = !st_r.prot || (link.wchk == mcf_check(link.wdata, generic_i));
    // one request per ack; the ack register blocks a second take
    take = link.req && !st_r.ack;
    wr_cfg0 = take && link.wr && chk_ok && hits_cfg0(link.addr);
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    // a strap is caught after release, never under the async reset
    if (!st_r.strap_done) begin
      st_nxt.prot = protect_pin_i;
      st_nxt.strap_done = 1'b1;
    end
    if (take) begin
      st_nxt.ack = 1'b1;
      st_nxt.err = link.wr && !chk_ok;
    end
    if (wr_cfg0) begin
      st_nxt = write_cfg0(st_nxt, link.wdata);
    end
    // read data stands until the next read
    if (take && !link.wr) begin
      st_nxt.rdata = rd;
      // check word always present; host ignores it with protection off
      st_nxt.rchk = mcf_check(rd, generic_i);
    end
    // toggle bit is always tracked; rewrite is only flagged with retry on
    if (chunk_valid_i) begin
      st_nxt.last_toggle = chunk_toggle_bit_i;
      st_nxt.rewrite_ok = st_r.retry_on && (chunk_toggle_bit_i == st_r.last_toggle);
    end else begin
      st_nxt.rewrite_ok = 1'b0;
    end
    // chunk size has no meaning on the generic protocol
    st_nxt.chunk_bytes = payload_bytes(st_nxt.chunk_payload_selector, generic_i);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.ack = st_r.ack;
  assign link.err = st_r.err;
  assign link.rdata = st_r.rdata;
  assign link.rchk = st_r.rchk;
  assign rx_cut_through_on_o = st_r.rx_ct;
  assign frame_stamp_on_o = st_r.stamp_on;
  assign stamp_size_select_o = st_r.stamp_64;
  assign control_protection_on_o = st_r.prot;
  assign chunk_retry_on_o = st_r.retry_on;
  assign rewrite_ok_o = st_r.rewrite_ok;
  assign chunk_bytes_o = st_r.chunk_bytes;
  assign sync_o = st_r.sync;
  assign chk_err_o = st_r.err;
endmodule : mcf_dev

/* design/mcf_regs.svh */
// register offsets, field positions and the selector reset value for the config fields
// included by both ends; definitions only
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH
`define MCF_CFG0_ADDR 8'h04
`define MCF_CAP_ADDR 8'h02
`define MCF_SYNC_BIT 15
`define MCF_RXCT_BIT 8
`define MCF_STAMP_BIT 7
`define MCF_SIZE_BIT 6
`define MCF_PROT_BIT 5
`define MCF_RETRY_BIT 4
`define MCF_CPS_HI 2
`define MCF_CPS_LO 0
`define MCF_CPS_RESET 3'h6
`define MCF_CPS_MIN 3'h3
`define MCF_CPS_MAX 3'h6
`define MCF_CRC_POLY 8'h07
`define MCF_ZERO32 32'h0000_0000
`define MCF_BYTES_ONE 8'h01
`endif

/* design/mcf_pkg.sv */
// types and check-word helpers shared by both ends of the config link
// assumes mcf_regs.svh is on the include path
`include "mcf_regs.svh"
package mcf_pkg;
  typedef logic [31:0] mcf_word_t;

  typedef enum logic [1:0] {
    MCF_IDLE = 2'b01,
    MCF_BUSY = 2'b10
  } mcf_hst_st_t;

  // crc8 over a data word, msb first
  function automatic logic [7:0] mcf_crc8(input mcf_word_t d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ `MCF_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : mcf_crc8

  // complement in chunk mode, crc8 in the low byte in generic mode
  function automatic mcf_word_t mcf_check(input mcf_word_t d, input logic generic);
    return generic ? {24'h00_0000, mcf_crc8(d)} : ~d;
  endfunction : mcf_check
endpackage : mcf_pkg

/* design/mcf_link_if.sv */
// word-level control channel between host end and device end
// one clock shared with both ends
`timescale 1ns/10ps
interface mcf_link_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] wchk;
  logic ack;
  logic [31:0] rdata;
  logic [31:0] rchk;
  logic err;
  modport dev (input req, input wr, input addr, input wdata, input wchk,
               output ack, output rdata, output rchk, output err);
  modport hst (output req, output wr, output addr, output wdata, output wchk,
               input ack, input rdata, input rchk, input err);
endinterface : mcf_link_if

/* design/mcf_hst.sv */
// host end: issues register commands and guards config ordering
// assumes the device answers each request with a one-cycle ack
`timescale 1ns/10ps
module mcf_hst (
  input wire logic core_clk_i,
  input wire logic rst_i,
  mcf_link_if.hst link,
  input wire logic generic_i,
  input wire logic protect_i,
  input wire logic rx_enabled_i,
  input wire logic frame_busy_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [31:0] cmd_data_i,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic chk_err_o,
  output logic [31:0] rdata_o
);
  import mcf_pkg::*;

  typedef struct packed {
    mcf_hst_st_t st;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] wchk;
    logic done;
    logic refused;
    logic chk_err;
    logic [31:0] rdata;
    logic sync_seen;
    logic [2:0] chunk_payload_selector;
  } mcf_hst_state_t;

  localparam mcf_hst_state_t RESET_STATE = '{
    st: MCF_IDLE, req: 1'b0, wr: 1'b0, addr: 8'h00, wdata: `MCF_ZERO32,
    wchk: `MCF_ZERO32, done: 1'b0, refused: 1'b0, chk_err: 1'b0,
    rdata: `MCF_ZERO32, sync_seen: 1'b0, chunk_payload_selector: `MCF_CPS_RESET};

  mcf_hst_state_t st_r;
  mcf_hst_state_t st_nxt;

  always_comb begin
    logic cps_change;
    logic bad;
    cps_change = cmd_data_i[`MCF_CPS_HI:`MCF_CPS_LO] != st_r.chunk_payload_selector;
    bad = 1'b0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.refused = 1'b0;
    case (st_r.st)
      MCF_IDLE: begin
        if (cmd_valid_i) begin
          if (cmd_wr_i && cmd_addr_i == `MCF_CFG0_ADDR) begin
            bad = cmd_data_i[`MCF_RXCT_BIT] && (generic_i || rx_enabled_i);
            bad = bad || (cps_change && (rx_enabled_i || frame_busy_i));
            bad = bad || (cps_change && st_r.sync_seen);
          end
          if (bad) begin
            st_nxt.done = 1'b1;
            st_nxt.refused = 1'b1;
          end else begin
            st_nxt.st = MCF_BUSY;
            st_nxt.req = 1'b1;
            st_nxt.wr = cmd_wr_i;
            st_nxt.addr = cmd_addr_i;
            st_nxt.wdata = cmd_data_i;
            st_nxt.wchk = mcf_check(cmd_data_i, generic_i);
            if (cmd_wr_i && cmd_addr_i == `MCF_CFG0_ADDR) begin
              st_nxt.chunk_payload_selector = cmd_data_i[`MCF_CPS_HI:`MCF_CPS_LO];
              st_nxt.sync_seen = st_r.sync_seen || cmd_data_i[`MCF_SYNC_BIT];
            end
          end
        end
      end
      MCF_BUSY: begin
        if (link.ack) begin
          st_nxt.st = MCF_IDLE;
          st_nxt.req = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.rdata = link.rdata;
          // read check only matters with protection on
          st_nxt.chk_err = link.err ||
            (!st_r.wr && protect_i && link.rchk != mcf_check(link.rdata, generic_i));
        end
      end
      default: st_nxt = RESET_STATE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.req = st_r.req;
  assign link.wr = st_r.wr;
  assign link.addr = st_r.addr;
  assign link.wdata = st_r.wdata;
  assign link.wchk = st_r.wchk;
  assign busy_o = st_r.req;
  assign done_o = st_r.done;
  assign refused_o = st_r.refused;
  assign chk_err_o = st_r.chk_err;
  assign rdata_o = st_r.rdata;
endmodule : mcf_hst

/* tb/mcf_link_sva.sv */
// link checker for the config channel between host end and device end
// instantiated by the bench beside the link; one clock, async reset
`timescale 1ns/10ps
`include "mcf_regs.svh"
module mcf_link_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wchk,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic [31:0] rchk
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_cfg = ack && !wr && addr == `MCF_CFG0_ADDR;
  a_ack_one_late: assert property ($rose(req) |=> ack) else $error("ack late");
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_req_drop_after: assert property (ack |-> req ##1 !req) else $error("req held");
  a_fields_held: assert property (
    req && !ack |=> $stable({wr, addr, wdata, wchk})) else $error("fields moved");
  a_wchk_form: assert property (
    req && wr |-> wchk == ~wdata || wchk[31:8] == 24'h00_0000) else $error("bad write check");
  a_rchk_form: assert property (
    ack && !wr |-> rchk == ~rdata || rchk[31:8] == 24'h00_0000) else $error("bad read check");
  a_cfg_resv_zero: assert property (
    rd_cfg |-> rdata[3] == 1'h0 && rdata[31:16] == 16'h0000) else $error("reserved set");
  a_cps_in_range: assert property (
    rd_cfg |-> rdata[2:0] inside {[`MCF_CPS_MIN:`MCF_CPS_MAX]})
    else $error("cps out of range");
  a_cap_min_size: assert property (
    ack && !wr && addr == `MCF_CAP_ADDR |-> rdata[2:0] == `MCF_CPS_MIN)
    else $error("cap min wrong");
  c_write: cover property (ack && wr);
  c_cfg_read: cover property (rd_cfg);
  c_sync_read: cover property (rd_cfg && rdata[15]);
endmodule : mcf_link_sva

/* tb/tb_macphy_spi_config_fields.sv */
// bench for both config ends joined by one link, plus a lone device end
// whose link the bench drives with one broken and one good check word
`timescale 1ns/10ps
`include "mcf_regs.svh"
module tb_macphy_spi_config_fields;
  import mcf_pkg::*;
  logic core_clk_i = 1'h0, rst_i = 1'h1, gen = 1'h0, prot = 1'h1, rx_en = 1'h0;
  logic fbusy = 1'h0, cval = 1'h0, ctog = 1'h0, cmd_v = 1'h0, cmd_w = 1'h0, bad_err;
  logic rxct, stamp, ssel, prot_o, retry, rew, sync, busy, done, refused, hchk, bstamp;
  logic [7:0] cmd_a = 8'h00, cbytes;
  logic [31:0] cmd_d = 32'h0000_0000, hrd;
  int errors = 0, check_count = 0;
  mcf_link_if link();
  mcf_link_if bad_link();
  mcf_dev u_mcf_dev (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .generic_i(gen),
    .protect_pin_i(prot), .chunk_valid_i(cval), .chunk_toggle_bit_i(ctog),
    .rx_cut_through_on_o(rxct), .frame_stamp_on_o(stamp), .stamp_size_select_o(ssel),
    .control_protection_on_o(prot_o), .chunk_retry_on_o(retry), .rewrite_ok_o(rew),
    .chunk_bytes_o(cbytes), .sync_o(sync), .chk_err_o());
  mcf_hst u_mcf_hst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .generic_i(gen),
    .protect_i(prot), .rx_enabled_i(rx_en), .frame_busy_i(fbusy), .cmd_valid_i(cmd_v),
    .cmd_wr_i(cmd_w), .cmd_addr_i(cmd_a), .cmd_data_i(cmd_d), .busy_o(busy), .done_o(done),
    .refused_o(refused), .chk_err_o(hchk), .rdata_o(hrd));
  mcf_dev u_mcf_dev_bad (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(bad_link),
    .generic_i(1'h0), .protect_pin_i(1'h1), .chunk_valid_i(1'h0), .chunk_toggle_bit_i(1'h0),
    .rx_cut_through_on_o(), .frame_stamp_on_o(bstamp), .stamp_size_select_o(),
    .control_protection_on_o(), .chunk_retry_on_o(), .rewrite_ok_o(), .chunk_bytes_o(),
    .sync_o(), .chk_err_o());
  mcf_link_sva u_mcf_link_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .wchk(link.wchk), .ack(link.ack),
    .rdata(link.rdata), .rchk(link.rchk));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cmd(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xref);
    @(posedge core_clk_i);
    #2 {cmd_v, cmd_w, cmd_a, cmd_d} = {1'h1, w, a, d};
    @(posedge core_clk_i);
    #2 cmd_v = 1'h0;
    for (int n = 0; n < 8 && done !== 1'h1; n++) begin
      @(posedge core_clk_i);
      #2;
    end
    chk("done", done, 1'h1);
    chk("refused", refused, xref);
  endtask : cmd
  task rd(input logic [7:0] a, input logic [31:0] exp);
    cmd(1'h0, a, 32'h0000_0000, 1'h0);
    chk("rdata", hrd, exp);
  endtask : rd
  task chunk(input logic tog, input logic exp);
    @(posedge core_clk_i);
    #2 {cval, ctog} = {1'h1, tog};
    @(posedge core_clk_i);
    #2 cval = 1'h0;
    chk("rewrite", rew, exp);
  endtask : chunk
  task reset_dut;
    #2 rst_i = 1'h1;
    repeat (2) @(posedge core_clk_i);
    #2 rst_i = 1'h0;
    repeat (2) @(posedge core_clk_i);
    #2;
  endtask : reset_dut
  task t_fields;
    rd(`MCF_CFG0_ADDR, 32'h0000_0026);
    chk("bytes", cbytes, 8'h40);
    cmd(1'h1, `MCF_CFG0_ADDR, 32'hFFFF_FFDB, 1'h0);
    chk("flags", {rxct, stamp, ssel, prot_o, retry, sync}, 6'h3F);
    chk("bytes", cbytes, 8'h08);
    rd(`MCF_CFG0_ADDR, 32'h0000_81F3);
    chunk(1'h1, 1'h0);
    chunk(1'h1, 1'h1);
    chunk(1'h0, 1'h0);
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0006, 1'h1);
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0003, 1'h0);
    rd(`MCF_CFG0_ADDR, 32'h0000_8023);
    chunk(1'h1, 1'h0);
    chunk(1'h1, 1'h0);
  endtask : t_fields
  task t_refuse;
    reset_dut();
    rx_en = 1'h1;
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0106, 1'h1);
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0004, 1'h1);
    {rx_en, fbusy} = 2'h1;
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0004, 1'h1);
    fbusy = 1'h0;
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0007, 1'h0);
    rd(`MCF_CFG0_ADDR, 32'h0000_0026);
    for (int k = 3; k <= 6; k++) begin
      cmd(1'h1, `MCF_CFG0_ADDR, k, 1'h0);
      chk("bytes", cbytes, 8'h01 << k);
    end
  endtask : t_refuse
  task t_generic;
    gen = 1'h1;
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0106, 1'h1);
    chk("bytes", cbytes, 8'h00);
    cmd(1'h1, `MCF_CFG0_ADDR, 32'h0000_0086, 1'h0);
    rd(`MCF_CFG0_ADDR, 32'h0000_00A6);
    chk("host check", hchk, 1'h0);
    gen = 1'h0;
    rd(`MCF_CAP_ADDR, 32'h0000_0003);
    rd(8'h7F, 32'h0000_0000);
  endtask : t_generic
  task bad_wr(input logic [31:0] c);
    @(posedge core_clk_i);
    #2 {bad_link.req, bad_link.wr, bad_link.wchk} = {2'h3, c};
    for (int n = 0; n < 8 && bad_link.ack !== 1'h1; n++) begin
      @(posedge core_clk_i);
      #2;
    end
    // hold the request through the edge that samples ack, take err there
    @(posedge core_clk_i);
    bad_err = bad_link.err;
    #2 {bad_link.req, bad_link.wdata, bad_link.wchk} = {1'h0, ~bad_link.wdata, ~c};
  endtask : bad_wr
  task t_badchk;
    bad_link.wdata = 32'h0000_0086;
    bad_wr(32'h0000_0000);
    chk("err", bad_err, 1'h1);
    chk("stamp", bstamp, 1'h0);
    bad_link.wdata = 32'h0000_0086;
    bad_wr(32'hFFFF_FF79);
    chk("err", bad_err, 1'h0);
    chk("stamp", bstamp, 1'h1);
  endtask : t_badchk
  task complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    {bad_link.req, bad_link.wr, bad_link.addr} = {2'h0, `MCF_CFG0_ADDR};
    {bad_link.wdata, bad_link.wchk} = 64'h0000_0000_FFFF_FFFF;
    repeat (20) @(posedge core_clk_i);
    #2 rst_i = 1'h0;
    repeat (2) @(posedge core_clk_i);
    t_fields();
    t_refuse();
    t_generic();
    t_badchk();
    complete_run();
  end
  // whole run needs about 120 cycles; generous margin
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule : tb_macphy_spi_config_fields
